/* dcc_pkg.sv */
// Package with register map, field layout and constants for the dual comparator control
package dcc_pkg;
    localparam logic [7:0] ADDR_CTRL0   = 8'h9E;
    localparam logic [7:0] ADDR_CTRL1   = 8'h9F;
    localparam logic [7:0] CTRL_RESET   = 8'h00;
    localparam int         BIT_ON       = 7;
    localparam int         BIT_RESULT   = 6;
    localparam int         BIT_RISE     = 5;
    localparam int         BIT_FALL     = 4;
    localparam int         POS_HI       = 3;
    localparam int         POS_LO       = 2;
    localparam int         NEG_HI       = 1;
    localparam int         NEG_LO       = 0;
    localparam int         NUM_CMP      = 2;
    // Hysteresis codes driven to the analog core
    localparam logic [1:0] HYST_OFF     = 2'h0;
    localparam logic [1:0] HYST_2MV     = 2'h1;
    localparam logic [1:0] HYST_4MV     = 2'h2;
    localparam logic [1:0] HYST_10MV    = 2'h3;

    typedef struct packed {
        logic       on;
        logic       rise_flag;
        logic       fall_flag;
        logic [1:0] pos_hyst_sel;
        logic [1:0] neg_hyst_sel;
    } dcc_ctrl_t;

    localparam dcc_ctrl_t CTRL_INIT = '{1'b0, 1'b0, 1'b0, HYST_OFF, HYST_OFF};
endpackage : dcc_pkg

/* dcc_sync_if.sv */
// Interface carrying one synchronised comparator result and its edge pulses
`timescale 1ns/10ps
interface dcc_sync_if;
    logic level;
    logic rise;
    logic fall;
    modport src (output level, output rise, output fall);
    modport dst (input level, input rise, input fall);
endinterface : dcc_sync_if

/* dcc_sync.sv */
// Two-stage synchroniser with edge detection for one comparator output
`timescale 1ns/10ps
module dcc_sync (
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic raw_in,
    dcc_sync_if.src   sync
);
    typedef struct packed {
        logic meta;
        logic stable;
        logic last;
    } dcc_sync_state_t;

    dcc_sync_state_t state;
    dcc_sync_state_t next_state;

    always_comb begin
        next_state        = state;
        next_state.meta   = raw_in;
        next_state.stable = state.meta;
        next_state.last   = state.stable;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign sync.level = state.stable;
    assign sync.rise  = state.stable & ~state.last;
    assign sync.fall  = ~state.stable & state.last;

    property p_sync_delay;
        @(posedge clk) disable iff (reset)
        $rose(raw_in) ##1 raw_in |=> sync.level;
    endproperty
    a_sync_delay: assert property (p_sync_delay) else $error("Level not synced in two cycles");
endmodule : dcc_sync

/* dcc_top.sv */
// Control and status logic for two voltage comparators
// What this block does
// - Bit 7 write turns comparator on/off
// - Disabled: pin output low, interrupts suspended
// - Detect rising and falling output edges
// - Falling edge sets bit 4 flag
// - Rising edge sets bit 5 flag
// - Flags stay set until software clears
// - Bit 6 shows present comparator result
// - Bits 3-2 select positive hysteresis
// - Bits 1-0 select negative hysteresis
// - Only comparator0 may request device reset
// - Comparator1 mirrors comparator0 layout
// - Pin driver open-drain or push-pull
`timescale 1ns/10ps
module dcc_top (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    input  wire logic [1:0] cmp_raw,
    input  wire logic [1:0] pin_open_drain,
    input  wire logic       cmp0_reset_src_en,
    output logic      [1:0] cmp_power_on,
    output logic      [1:0] pos_hyst_sel,
    output logic      [1:0] neg_hyst_sel_0,
    output logic      [1:0] pos_hyst_sel_1,
    output logic      [1:0] neg_hyst_sel_1,
    output logic      [1:0] pin_out,
    output logic      [1:0] pin_oe,
    output logic      [1:0] rise_event,
    output logic      [1:0] fall_event,
    output logic            cmp0_reset_req
);
    typedef struct packed {
        dcc_pkg::dcc_ctrl_t [1:0] ctrl;
        logic [1:0]               route;
        logic [1:0]               rise_evt;
        logic [1:0]               fall_evt;
        logic                     reset_req;
        logic [7:0]               rdata;
    } dcc_state_t;

    dcc_state_t state;
    dcc_state_t next_state;
    logic [1:0] level;
    logic [1:0] rise;
    logic [1:0] fall;
    logic [1:0] wr_hit;

    genvar g;
    generate
        for (g = 0; g < dcc_pkg::NUM_CMP; g++) begin : g_cmp
            dcc_sync_if sif ();
            dcc_sync u_sync (
                .clk    (clk),
                .reset  (reset),
                .raw_in (cmp_raw[g]),
                .sync   (sif.src)
            );
            assign level[g] = sif.level;
            assign rise[g]  = sif.rise;
            assign fall[g]  = sif.fall;
        end
    endgenerate

    assign wr_hit[0] = reg_wr && (reg_addr == dcc_pkg::ADDR_CTRL0);
    assign wr_hit[1] = reg_wr && (reg_addr == dcc_pkg::ADDR_CTRL1);

    function automatic logic [7:0] pack_ctrl(input dcc_pkg::dcc_ctrl_t c, input logic res);
        logic [7:0] v;
        v                       = '0;
        v[dcc_pkg::BIT_ON]      = c.on;
        v[dcc_pkg::BIT_RESULT]  = res;
        v[dcc_pkg::BIT_RISE]    = c.rise_flag;
        v[dcc_pkg::BIT_FALL]    = c.fall_flag;
        v[dcc_pkg::POS_HI:dcc_pkg::POS_LO] = c.pos_hyst_sel;
        v[dcc_pkg::NEG_HI:dcc_pkg::NEG_LO] = c.neg_hyst_sel;
        return v;
    endfunction : pack_ctrl

    always_comb begin
        next_state = state;
        for (int i = 0; i < dcc_pkg::NUM_CMP; i++) begin
            if (wr_hit[i]) begin
                next_state.ctrl[i].on           = reg_wdata[dcc_pkg::BIT_ON];
                next_state.ctrl[i].rise_flag    = reg_wdata[dcc_pkg::BIT_RISE];
                next_state.ctrl[i].fall_flag    = reg_wdata[dcc_pkg::BIT_FALL];
                next_state.ctrl[i].pos_hyst_sel =
                    reg_wdata[dcc_pkg::POS_HI:dcc_pkg::POS_LO];
                next_state.ctrl[i].neg_hyst_sel =
                    reg_wdata[dcc_pkg::NEG_HI:dcc_pkg::NEG_LO];
            end
            // Edge sets win over a same-cycle software write
            if (state.ctrl[i].on && rise[i]) begin
                next_state.ctrl[i].rise_flag = 1'b1;
            end
            if (state.ctrl[i].on && fall[i]) begin
                next_state.ctrl[i].fall_flag = 1'b1;
            end
            next_state.rise_evt[i] = state.ctrl[i].on & rise[i];
            next_state.fall_evt[i] = state.ctrl[i].on & fall[i];
            next_state.route[i]    = state.ctrl[i].on & level[i];
        end
        // Reset request on comparator0 low result while enabled
        next_state.reset_req = cmp0_reset_src_en & state.ctrl[0].on & ~level[0];
        if (reg_addr == dcc_pkg::ADDR_CTRL0) begin
            next_state.rdata = pack_ctrl(state.ctrl[0], level[0]);
        end else if (reg_addr == dcc_pkg::ADDR_CTRL1) begin
            next_state.rdata = pack_ctrl(state.ctrl[1], level[1]);
        end else begin
            next_state.rdata = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state      <= '0;
            state.ctrl <= {dcc_pkg::CTRL_INIT, dcc_pkg::CTRL_INIT};
        end else begin
            state <= next_state;
        end
    end

    assign reg_rdata      = state.rdata;
    assign cmp_power_on   = {state.ctrl[1].on, state.ctrl[0].on};
    assign pos_hyst_sel   = state.ctrl[0].pos_hyst_sel;
    assign neg_hyst_sel_0 = state.ctrl[0].neg_hyst_sel;
    assign pos_hyst_sel_1 = state.ctrl[1].pos_hyst_sel;
    assign neg_hyst_sel_1 = state.ctrl[1].neg_hyst_sel;
    assign rise_event     = state.rise_evt;
    assign fall_event     = state.fall_evt;
    assign cmp0_reset_req = state.reset_req;
    // Open drain drives only the low level; push-pull drives always
    generate
        for (g = 0; g < dcc_pkg::NUM_CMP; g++) begin : g_pin
            assign pin_out[g] = state.route[g];
            assign pin_oe[g]  = pin_open_drain[g] ? ~state.route[g] : 1'b1;
        end
    endgenerate

    property p_off_low;
        @(posedge clk) disable iff (reset)
        !state.ctrl[0].on |=> !pin_out[0];
    endproperty
    a_off_low: assert property (p_off_low) else $error("Disabled output not low");

    property p_off_no_evt;
        @(posedge clk) disable iff (reset)
        !state.ctrl[1].on |=> !rise_event[1] && !fall_event[1];
    endproperty
    a_off_no_evt: assert property (p_off_no_evt) else $error("Event while disabled");

    property p_on_write;
        @(posedge clk) disable iff (reset)
        wr_hit[0] |=> cmp_power_on[0] == $past(reg_wdata[dcc_pkg::BIT_ON]);
    endproperty
    a_on_write: assert property (p_on_write) else $error("Enable write lost");

    property p_rise_set;
        @(posedge clk) disable iff (reset)
        state.ctrl[0].on && rise[0] |=> state.ctrl[0].rise_flag;
    endproperty
    a_rise_set: assert property (p_rise_set) else $error("Rise flag not set");

    property p_fall_set;
        @(posedge clk) disable iff (reset)
        state.ctrl[1].on && fall[1] |=> state.ctrl[1].fall_flag;
    endproperty
    a_fall_set: assert property (p_fall_set) else $error("Fall flag not set");

    property p_sticky;
        @(posedge clk) disable iff (reset)
        state.ctrl[0].rise_flag && !wr_hit[0] |=> state.ctrl[0].rise_flag;
    endproperty
    a_sticky: assert property (p_sticky) else $error("Flag cleared without write");

    property p_result;
        @(posedge clk) disable iff (reset)
        reg_addr == dcc_pkg::ADDR_CTRL1 |=> reg_rdata[dcc_pkg::BIT_RESULT] == $past(level[1]);
    endproperty
    a_result: assert property (p_result) else $error("Result bit wrong");

    property p_hyst;
        @(posedge clk) disable iff (reset)
        wr_hit[1] |=> pos_hyst_sel_1 == $past(reg_wdata[dcc_pkg::POS_HI:dcc_pkg::POS_LO])
                      && neg_hyst_sel_1 == $past(reg_wdata[dcc_pkg::NEG_HI:dcc_pkg::NEG_LO]);
    endproperty
    a_hyst: assert property (p_hyst) else $error("Hysteresis code wrong");

    property p_reset_src;
        @(posedge clk) disable iff (reset)
        cmp0_reset_req |-> $past(state.ctrl[0].on) && $past(cmp0_reset_src_en);
    endproperty
    a_reset_src: assert property (p_reset_src) else $error("Bad reset request");

    // Mirror checks for the other comparator, then further checks that each cover one comparator only
    property p_off_low_1;
        @(posedge clk) disable iff (reset)
        !state.ctrl[1].on |=> !pin_out[1];
    endproperty
    a_off_low_1: assert property (p_off_low_1) else $error("Output 1 not low");

    property p_off_no_evt_0;
        @(posedge clk) disable iff (reset)
        !state.ctrl[0].on |=> !rise_event[0] && !fall_event[0];
    endproperty
    a_off_no_evt_0: assert property (p_off_no_evt_0) else $error("Event 0 while off");

    property p_route_0;
        @(posedge clk) disable iff (reset)
        state.ctrl[0].on |=> pin_out[0] == $past(level[0]);
    endproperty
    a_route_0: assert property (p_route_0) else $error("Output 0 not routed");

    property p_on_write_1;
        @(posedge clk) disable iff (reset)
        wr_hit[1] |=> cmp_power_on[1] == $past(reg_wdata[dcc_pkg::BIT_ON]);
    endproperty
    a_on_write_1: assert property (p_on_write_1) else $error("Enable 1 write lost");

    property p_rise_set_1;
        @(posedge clk) disable iff (reset)
        state.ctrl[1].on && rise[1] |=> state.ctrl[1].rise_flag;
    endproperty
    a_rise_set_1: assert property (p_rise_set_1) else $error("Rise flag 1 not set");

    property p_fall_set_0;
        @(posedge clk) disable iff (reset)
        state.ctrl[0].on && fall[0] |=> state.ctrl[0].fall_flag;
    endproperty
    a_fall_set_0: assert property (p_fall_set_0) else $error("Fall flag 0 not set");

    property p_sticky_fall;
        @(posedge clk) disable iff (reset)
        state.ctrl[0].fall_flag && !wr_hit[0] |=> state.ctrl[0].fall_flag;
    endproperty
    a_sticky_fall: assert property (p_sticky_fall) else $error("Fall flag dropped");

    property p_sticky_1;
        @(posedge clk) disable iff (reset)
        state.ctrl[1].rise_flag && !wr_hit[1] |=> state.ctrl[1].rise_flag;
    endproperty
    a_sticky_1: assert property (p_sticky_1) else $error("Flag 1 dropped");

    property p_result_0;
        @(posedge clk) disable iff (reset)
        reg_addr == dcc_pkg::ADDR_CTRL0 |=> reg_rdata[dcc_pkg::BIT_RESULT] == $past(level[0]);
    endproperty
    a_result_0: assert property (p_result_0) else $error("Result bit 0 wrong");

    property p_hyst_0;
        @(posedge clk) disable iff (reset)
        wr_hit[0] |=> pos_hyst_sel == $past(reg_wdata[dcc_pkg::POS_HI:dcc_pkg::POS_LO])
                      && neg_hyst_sel_0 == $past(reg_wdata[dcc_pkg::NEG_HI:dcc_pkg::NEG_LO]);
    endproperty
    a_hyst_0: assert property (p_hyst_0) else $error("Hysteresis 0 wrong");

    property p_neg_hold_1;
        @(posedge clk) disable iff (reset)
        !wr_hit[1] |=> neg_hyst_sel_1 == $past(neg_hyst_sel_1);
    endproperty
    a_neg_hold_1: assert property (p_neg_hold_1) else $error("Neg code 1 moved");

    property p_pos_hold_0;
        @(posedge clk) disable iff (reset)
        !wr_hit[0] |=> pos_hyst_sel == $past(pos_hyst_sel);
    endproperty
    a_pos_hold_0: assert property (p_pos_hold_0) else $error("Pos code 0 moved");

    property p_push_pull;
        @(posedge clk) disable iff (reset)
        !pin_open_drain[1] |-> pin_oe[1];
    endproperty
    a_push_pull: assert property (p_push_pull) else $error("Push-pull not driven");

    property p_open_drain;
        @(posedge clk) disable iff (reset)
        pin_open_drain[0] |-> pin_oe[0] == !pin_out[0];
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("Open-drain enable wrong");

    property p_evt_pulse;
        @(posedge clk) disable iff (reset)
        rise_event[0] |=> !rise_event[0];
    endproperty
    a_evt_pulse: assert property (p_evt_pulse) else $error("Rise event too long");

    property p_reset_set;
        @(posedge clk) disable iff (reset)
        cmp0_reset_src_en && state.ctrl[0].on && !level[0] |=> cmp0_reset_req;
    endproperty
    a_reset_set: assert property (p_reset_set) else $error("Reset request missing");

    property p_fall_evt_1;
        @(posedge clk) disable iff (reset)
        state.ctrl[1].on && fall[1] |=> fall_event[1];
    endproperty
    a_fall_evt_1: assert property (p_fall_evt_1) else $error("Fall event 1 missing");

    c_rise:  cover property (@(posedge clk) disable iff (reset) rise_event[0]);
    c_fall:  cover property (@(posedge clk) disable iff (reset) fall_event[1]);
    c_rreq:  cover property (@(posedge clk) disable iff (reset) cmp0_reset_req);
    c_clear: cover property (@(posedge clk) disable iff (reset)
                             state.ctrl[0].rise_flag ##1 !state.ctrl[0].rise_flag);
    c_od:    cover property (@(posedge clk) disable iff (reset)
                             pin_open_drain[0] && !pin_oe[0]);
endmodule : dcc_top

/* dcc_cmp_model.sv */
// Behavioural model of the two analog comparator cores
`timescale 1ns/10ps
module dcc_cmp_model (
    output logic [1:0] cmp_out
);
    logic [1:0] level = 2'h0;
    // The core reports its input difference only; the block does the gating
    assign cmp_out = level;
    task automatic set_level(input int n, input logic v);
        level[n] = v;
    endtask : set_level
endmodule : dcc_cmp_model

/* tb_top.sv */
// Self-checking testbench for the dual comparator control block
`timescale 1ns/10ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin miscompares++; \
    $display("[ERR] %0t got %h exp %h", $time, got, exp); end end
module tb_top;
    logic       clk = 1'b0;
    logic       reset = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic       reg_wr = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic [1:0] cmp_raw;
    logic [1:0] pin_open_drain = 2'h0;
    logic       cmp0_reset_src_en = 1'b0;
    logic [1:0] cmp_power_on, pos_hyst_sel, neg_hyst_sel_0, pos_hyst_sel_1, neg_hyst_sel_1;
    logic [1:0] pin_out, pin_oe, rise_event, fall_event;
    logic       cmp0_reset_req;
    logic [1:0] cc;
    logic [7:0] ctl;
    int         miscompares = 0;
    int         compares = 0;
    int         pulses;
    always #20 clk = ~clk;
    dcc_top u_dcc_top (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .cmp_raw(cmp_raw),
        .pin_open_drain(pin_open_drain), .cmp0_reset_src_en(cmp0_reset_src_en),
        .cmp_power_on(cmp_power_on), .pos_hyst_sel(pos_hyst_sel),
        .neg_hyst_sel_0(neg_hyst_sel_0), .pos_hyst_sel_1(pos_hyst_sel_1),
        .neg_hyst_sel_1(neg_hyst_sel_1), .pin_out(pin_out), .pin_oe(pin_oe),
        .rise_event(rise_event), .fall_event(fall_event), .cmp0_reset_req(cmp0_reset_req));
    dcc_cmp_model u_dcc_cmp_model (.cmp_out(cmp_raw));
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask : wr
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk);
        reg_addr = a;
        @(negedge clk);
        `CHK(reg_rdata, e)
    endtask : rdchk
    // Moves one comparator output and counts the matching event pulses
    task automatic drive(input int n, input logic v);
        @(negedge clk);
        u_dcc_cmp_model.set_level(n, v);
        pulses = 0;
        repeat (5) begin
            @(negedge clk);
            pulses += ((v ? rise_event[n] : fall_event[n]) === 1'b1);
        end
    endtask : drive
    task automatic complete_run;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : complete_run
    initial begin
        repeat (8) @(negedge clk);
        reset = 1'b0;
        rdchk(dcc_pkg::ADDR_CTRL0, dcc_pkg::CTRL_RESET);
        rdchk(dcc_pkg::ADDR_CTRL1, dcc_pkg::CTRL_RESET);
        rdchk(8'h9D, 8'h00);
        $display("test reset done");
        for (int n = 0; n < 2; n++) begin
            for (int c = 0; c < 4; c++) begin
                cc = 2'(c);
                ctl = {1'b1, 3'h0, cc, ~cc};
                wr(dcc_pkg::ADDR_CTRL0 + 8'(n), ctl | 8'h40);
                wr(8'h9D, 8'h00);
                rdchk(dcc_pkg::ADDR_CTRL0 + 8'(n), ctl);
                `CHK(cmp_power_on[n], 1'b1)
                `CHK(n ? pos_hyst_sel_1 : pos_hyst_sel, cc)
                `CHK(n ? neg_hyst_sel_1 : neg_hyst_sel_0, ~cc)
            end
        end
        $display("test hysteresis done");
        for (int n = 0; n < 2; n++) begin
            wr(dcc_pkg::ADDR_CTRL0 + 8'(n), 8'h80);
            drive(n, 1'b1);
            `CHK(pulses, 1)
            `CHK(pin_out[n], 1'b1)
            rdchk(dcc_pkg::ADDR_CTRL0 + 8'(n), 8'hE0);
            drive(n, 1'b0);
            `CHK(pulses, 1)
            rdchk(dcc_pkg::ADDR_CTRL0 + 8'(n), 8'hB0);
            drive(n, 1'b1);
            drive(n, 1'b0);
            rdchk(dcc_pkg::ADDR_CTRL0 + 8'(n), 8'hB0);
            wr(dcc_pkg::ADDR_CTRL0 + 8'(n), 8'h80);
            rdchk(dcc_pkg::ADDR_CTRL0 + 8'(n), 8'h80);
            wr(dcc_pkg::ADDR_CTRL0 + 8'(n), 8'h00);
            `CHK(cmp_power_on[n], 1'b0)
            drive(n, 1'b1);
            `CHK(pulses, 0)
            `CHK(pin_out[n], 1'b0)
            rdchk(dcc_pkg::ADDR_CTRL0 + 8'(n), 8'h40);
            drive(n, 1'b0);
        end
        $display("test edges done");
        cmp0_reset_src_en = 1'b1;
        wr(dcc_pkg::ADDR_CTRL0, 8'h80);
        repeat (2) @(negedge clk);
        `CHK(cmp0_reset_req, 1'b1)
        pin_open_drain = 2'h1;
        drive(0, 1'b1);
        `CHK(cmp0_reset_req, 1'b0)
        `CHK(pin_oe[0], 1'b0)
        drive(0, 1'b0);
        `CHK(pin_oe[0], 1'b1)
        pin_open_drain = 2'h0;
        drive(0, 1'b1);
        `CHK(pin_oe, 2'h3)
        $display("test reset source and pins done");
        // Reset in mid-run with comparator0 high: registers clear, no false edge flagged
        @(negedge clk);
        reset = 1'b1;
        repeat (2) @(negedge clk);
        reset = 1'b0;
        repeat (2) @(negedge clk);
        `CHK(cmp_power_on, 2'h0)
        `CHK(cmp0_reset_req, 1'b0)
        `CHK(pin_out, 2'h0)
        rdchk(dcc_pkg::ADDR_CTRL0, 8'h40);
        rdchk(dcc_pkg::ADDR_CTRL1, dcc_pkg::CTRL_RESET);
        $display("test mid-run reset done");
        complete_run();
    end
endmodule : tb_top
